// >>> hbgd_cfg.svh
// Constants for the half-bridge gate mode control block.
`ifndef HBGD_CFG_SVH
`define HBGD_CFG_SVH

// Reset value of the bridge bypass flag.
`define HBGD_BYPASS_RST 1'b1
// Reset value of each half-bridge mode field.
`define HBGD_MODE_RST 2'h0
// Reset value of each static gate current code.
`define HBGD_CUR_RST 4'h0
// Reset values of the hold current select and overcurrent shutdown enable.
`define HBGD_HOLD_RST 1'b0
`define HBGD_OVERCURRENT_SHUTDOWN_ENABLE_RST 1'b0
// Hold current codes for the low and high hold settings.
`define HBGD_HOLD_LO_CODE 4'h4
`define HBGD_HOLD_HI_CODE 4'h6
// Discharge setting code that the hard-off sink current equals.
`define HBGD_HARDOFF_CODE 5'h1F
// Clock rate in MHz and the longest command latency in ns.
`define HBGD_CLK_MHZ 200
`define HBGD_CMD_LAT_NS 3000
// Longest latency in cycles, rounded down.
`define HBGD_CMD_LAT_CYC ((`HBGD_CMD_LAT_NS * `HBGD_CLK_MHZ) / 1000)
// Cycles from a command strobe until the gate drive reflects it.
`define HBGD_CMD_APPLY_CYC 3

`endif

// >>> hbgd_pkg.sv
// Types shared by the half-bridge gate mode control block.
package hbgd_pkg;

    // Half-bridge mode field encoding.
    typedef enum logic [1:0] {
        HBGD_MODE_OFF  = 2'h0,
        HBGD_MODE_LS   = 2'h1,
        HBGD_MODE_HS   = 2'h2,
        HBGD_MODE_RSVD = 2'h3
    } hbgd_mode_t;

    // Gate drive of one driver: enable, source or sink, hard-off, current code.
    typedef struct packed {
        logic       en;
        logic       source;
        logic       hard;
        logic [3:0] code;
    } hbgd_drive_t;

    // Configuration written by one command.
    typedef struct packed {
        logic                 bypass;
        logic                 overcurrent_shutdown_enable;
        logic                 hold_sel;
        logic [7:0][1:0]      mode;
        logic [7:0][3:0]      cur;
        logic [7:0][7:0]      ccp_time;
        logic [7:0][7:0]      blank_time;
    } hbgd_cfg_t;

    // Supply and device faults that forbid active operation.
    typedef struct packed {
        logic vs_ov;
        logic vs_uv;
        logic cp_uv;
        logic over_temp;
        logic fail_safe;
    } hbgd_fault_t;

    // Sequencing states of one half-bridge, Gray coded in the order listed.
    typedef enum logic [2:0] {
        HBGD_ST_OFF    = 3'h0,
        HBGD_ST_CCP    = 3'h1,
        HBGD_ST_CHARGE = 3'h3,
        HBGD_ST_ON     = 3'h2,
        HBGD_ST_TRIP   = 3'h6
    } hbgd_state_t;

endpackage

// >>> hbgd_leg.sv
// Switching sequencer for one half-bridge of the gate drive block.
`timescale 1ns/1ps
`include "hbgd_cfg.svh"

module hbgd_leg
    import hbgd_pkg::*;
#(
    parameter int TW = 8
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          run,        // Bridge driver is in active mode.
    input  wire logic          trip,       // Shutdown request for this bridge.
    input  wire logic [1:0]    mode,       // Half-bridge mode field.
    input  wire logic [3:0]    cur,        // Static gate current code.
    input  wire logic          hold_sel,   // Hold current select.
    input  wire logic [TW-1:0] ccp_time,   // Cross-conduction guard time.
    input  wire logic [TW-1:0] blank_time, // Drain-source blank time.
    output hbgd_drive_t        hs_drv,     // High-side gate drive.
    output hbgd_drive_t        ls_drv,     // Low-side gate drive.
    output logic               hs_on,      // High-side switch is commanded on.
    output logic               ls_on       // Low-side switch is commanded on.
);

    hbgd_state_t   state_r;     // Current sequencing state.
    hbgd_state_t   state_nxt;   // Next sequencing state.
    logic [TW-1:0] cnt_r;       // Phase timer.
    logic [TW-1:0] cnt_nxt;     // Next phase timer value.
    logic          side_r;      // Side held on: 1 high, 0 low.
    logic          side_nxt;    // Next held side.
    logic          want_on;     // Mode asks for one side on.
    logic          want_side;   // Side that the mode asks for.
    logic [3:0]    hold_code;   // Current code used for holding.
    hbgd_drive_t   hs_nxt;      // Next high-side drive.
    hbgd_drive_t   ls_nxt;      // Next low-side drive.

    // Decode the mode; off and reserved both hold the bridge off.
    always_comb begin
        want_on   = (mode == HBGD_MODE_LS) || (mode == HBGD_MODE_HS);
        want_side = (mode == HBGD_MODE_HS);
        hold_code = hold_sel ? `HBGD_HOLD_HI_CODE : `HBGD_HOLD_LO_CODE;
    end

    // Pick the next state and phase time; mapping to PWM is absent so the switch is static.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r != '0) ? cnt_r - TW'(1) : cnt_r;
        side_nxt  = side_r;
        if (!run) begin
            // Passive operation parks the sequencer.
            state_nxt = HBGD_ST_OFF;
            cnt_nxt   = '0;
        end else if (trip) begin
            state_nxt = HBGD_ST_TRIP;
            cnt_nxt   = '0;
        end else begin
            unique case (state_r)
                HBGD_ST_OFF: begin
                    if (want_on) begin
                        // Nothing conducts, so charge at once.
                        state_nxt = HBGD_ST_CHARGE;
                        side_nxt  = want_side;
                        cnt_nxt   = blank_time;
                    end
                end
                HBGD_ST_ON: begin
                    if (!want_on || (want_side != side_r)) begin
                        // Discharge both gates before anything else.
                        state_nxt = HBGD_ST_CCP;
                        cnt_nxt   = ccp_time;
                    end
                end
                HBGD_ST_CHARGE: begin
                    if (!want_on || (want_side != side_r)) begin
                        state_nxt = HBGD_ST_CCP;
                        cnt_nxt   = ccp_time;
                    end else if (cnt_r == '0) begin
                        state_nxt = HBGD_ST_ON;
                    end
                end
                HBGD_ST_CCP: begin
                    if (cnt_r == '0) begin
                        if (want_on) begin
                            state_nxt = HBGD_ST_CHARGE;
                            side_nxt  = want_side;
                            cnt_nxt   = blank_time;
                        end else begin
                            state_nxt = HBGD_ST_OFF;
                        end
                    end
                end
                HBGD_ST_TRIP: begin
                    // Stay off until the shutdown request is withdrawn.
                    state_nxt = HBGD_ST_OFF;
                end
                default: begin
                    state_nxt = HBGD_ST_OFF;
                end
            endcase
        end
    end

    // Form the drive of both gates from the next state.
    always_comb begin
        hs_nxt = '{en: run, source: 1'b0, hard: 1'b0, code: hold_code};
        ls_nxt = '{en: run, source: 1'b0, hard: 1'b0, code: hold_code};
        unique case (state_nxt)
            HBGD_ST_CCP, HBGD_ST_TRIP: begin
                // Both gates sink the static current.
                hs_nxt.code = cur;
                ls_nxt.code = cur;
            end
            HBGD_ST_CHARGE: begin
                // Charge the chosen gate, hard-hold the other off.
                if (side_nxt) begin
                    hs_nxt = '{en: run, source: 1'b1, hard: 1'b0, code: cur};
                    ls_nxt.hard = 1'b1;
                end else begin
                    ls_nxt = '{en: run, source: 1'b1, hard: 1'b0, code: cur};
                    hs_nxt.hard = 1'b1;
                end
            end
            HBGD_ST_ON: begin
                // Hold the chosen gate on, the other off.
                if (side_nxt) begin
                    hs_nxt.source = 1'b1;
                end else begin
                    ls_nxt.source = 1'b1;
                end
            end
            default: begin
                // Off state holds both gates with the hold sink current.
            end
        endcase
    end

    // State, timer and held side.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= HBGD_ST_OFF;
            cnt_r   <= '0;
            side_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            side_r  <= side_nxt;
        end
    end

    // Registered drive outputs.
    always_ff @(posedge mclk) begin
        if (rst) begin
            hs_drv <= '0;
            ls_drv <= '0;
            hs_on  <= 1'b0;
            ls_on  <= 1'b0;
        end else begin
            hs_drv <= hs_nxt;
            ls_drv <= ls_nxt;
            hs_on  <= hs_nxt.source;
            ls_on  <= ls_nxt.source;
        end
    end

endmodule

// >>> hbgd_ctrl.sv
// Active or passive decision and per-bridge drive for eight half-bridges.
`timescale 1ns/1ps
`include "hbgd_cfg.svh"

//
// Contract
// - Reset: bypass set, all modes off.
// - Bypass cleared with enable high: active.
// - Bypass set but a bridge on: active.
// - Enable low, or bypass set and all off: passive.
// - Supply, temperature, fail-safe faults forbid active.
// - Codes 00 and 11 hold both off.
// - 01 low side on, 10 high side.
// - Unmapped bridges switch statically.
// - Sixteen drivers as eight half-bridges.
// - Hard-off sink holds opposite side off.
// - Static code selects monotonic gate current.
// - Hold select low: hold code 0100.
// - Hold select high: hold code 0110.
// - Faults turn off with static discharge.
// - Each bridge uses its own times.
// - Commands act within 3 microseconds.
// - Side swap: discharge, then charge, hard-off.
// - All off: discharge, then hold sink.
//
// The host keeps the mode fields at off or reserved before it clears the
// bypass flag the logic does not enforce that, it only obeys.
//

module hbgd_ctrl
    import hbgd_pkg::*;
#(
    parameter int NUM_HB = 8, // Number of half-bridges.
    parameter int TW     = 8  // Width of the per-bridge time fields.
) (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   en,          // Enable pin level.
    input  wire logic                   cmd_valid,   // One-cycle command strobe.
    input  wire hbgd_cfg_t              cmd_cfg,     // Configuration of the command.
    input  wire hbgd_fault_t            fault,       // Device-wide fault levels.
    input  wire logic [NUM_HB-1:0]      ds_ov,       // Drain-source overvoltage.
    input  wire logic [NUM_HB-1:0]      oc,          // Overcurrent per bridge.
    output logic                        drv_active,  // Gate drivers are active.
    output logic [NUM_HB-1:0]           trip_state,  // Bridge is shut down.
    output hbgd_drive_t [NUM_HB-1:0]    hs_drv,      // High-side gate drives.
    output hbgd_drive_t [NUM_HB-1:0]    ls_drv,      // Low-side gate drives.
    output logic [NUM_HB-1:0]           high_side_switch, // High side on.
    output logic [NUM_HB-1:0]           low_side_switch   // Low side on.
);

    // Refuse sizes that the configuration record cannot carry.
    if (NUM_HB < 1 || NUM_HB > 8 || TW != 8) begin : g_bad_size
        $error("hbgd_ctrl supports one to eight bridges and 8-bit times");
    end

    // Refuse an apply latency beyond the allowed command latency.
    if (`HBGD_CMD_APPLY_CYC > `HBGD_CMD_LAT_CYC) begin : g_bad_lat
        $error("hbgd_ctrl command latency too long");
    end

    hbgd_cfg_t         cfg_r;        // Configuration in force.
    logic              run_r;        // Enable and mode logic ask for active.
    logic              run_nxt;      // Next value of run_r.
    logic              any_on;       // Some bridge holds code 01 or 10.
    logic              dev_fault;    // Any device-wide fault.
    logic [NUM_HB-1:0] trip_r;       // Latched shutdown per bridge.
    logic [NUM_HB-1:0] trip_set;     // Shutdown cause per bridge.
    logic              active_r;     // Active operation allowed.

    // Configuration register; a command replaces it whole.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_r.bypass     <= `HBGD_BYPASS_RST;
            cfg_r.overcurrent_shutdown_enable       <= `HBGD_OVERCURRENT_SHUTDOWN_ENABLE_RST;
            cfg_r.hold_sel   <= `HBGD_HOLD_RST;
            cfg_r.mode       <= {8{`HBGD_MODE_RST}};
            cfg_r.cur        <= {8{`HBGD_CUR_RST}};
            cfg_r.ccp_time   <= '0;
            cfg_r.blank_time <= '0;
        end else if (cmd_valid) begin
            // Taken on the strobe edge, well inside the latency bound.
            cfg_r <= cmd_cfg;
        end
    end

    // Decide active or passive from enable, bypass and the modes.
    always_comb begin
        any_on = 1'b0;
        for (int i = 0; i < NUM_HB; i++) begin
            if ((cfg_r.mode[i] == HBGD_MODE_LS) || (cfg_r.mode[i] == HBGD_MODE_HS)) begin
                any_on = 1'b1;
            end
        end
        // Enable low always wins; bypass set needs a bridge switched on.
        run_nxt   = en && (!cfg_r.bypass || any_on);
        dev_fault = fault.vs_ov || fault.vs_uv || fault.cp_uv ||
                    fault.over_temp || fault.fail_safe;
    end

    // Shutdown causes: device faults, the bridge's own overvoltage, overcurrent when enabled.
    always_comb begin
        for (int i = 0; i < NUM_HB; i++) begin
            trip_set[i] = run_r && (dev_fault || ds_ov[i] ||
                          (oc[i] && cfg_r.overcurrent_shutdown_enable));
        end
    end

    // Recomputed every cycle, so level changes act without a command.
    always_ff @(posedge mclk) begin
        if (rst) begin
            run_r    <= 1'b0;
            active_r <= 1'b0;
        end else begin
            run_r    <= run_nxt;
            active_r <= run_nxt && !dev_fault;
        end
    end

    // Latched shutdown; a new command clears it, but a cause in that cycle wins.
    always_ff @(posedge mclk) begin
        if (rst) begin
            trip_r <= '0;
        end else begin
            for (int i = 0; i < NUM_HB; i++) begin
                if (trip_set[i]) begin
                    trip_r[i] <= 1'b1;
                end else if (cmd_valid || !run_r) begin
                    trip_r[i] <= 1'b0;
                end
            end
        end
    end

    // Status outputs.
    always_ff @(posedge mclk) begin
        if (rst) begin
            drv_active <= 1'b0;
            trip_state <= '0;
        end else begin
            drv_active <= active_r;
            trip_state <= trip_r;
        end
    end

    // One sequencer per half-bridge, each high and low side a driver.
    for (genvar g = 0; g < NUM_HB; g++) begin : g_leg
        hbgd_leg #(
            .TW(TW)
        ) u_leg (
            .mclk       (mclk),
            .rst        (rst),
            .run        (run_r),
            .trip       (trip_r[g] || trip_set[g]),
            .mode       (cfg_r.mode[g]),
            .cur        (cfg_r.cur[g]),
            .hold_sel   (cfg_r.hold_sel),
            .ccp_time   (cfg_r.ccp_time[g]),
            .blank_time (cfg_r.blank_time[g]),
            .hs_drv     (hs_drv[g]),
            .ls_drv     (ls_drv[g]),
            .hs_on      (high_side_switch[g]),
            .ls_on      (low_side_switch[g])
        );
    end

endmodule

// >>> hbgd_chk.sv
// Concurrent assertions on the ports of the half-bridge gate mode control block.
`timescale 1ns/1ps

module hbgd_chk
    import hbgd_pkg::*;
#(
    parameter int NUM_HB = 8, // Number of half-bridges.
    parameter int TW     = 8  // Width of the per-bridge time fields.
) (
    input wire logic                     mclk,
    input wire logic                     rst,
    input wire logic                     en,
    input wire logic                     cmd_valid,
    input wire hbgd_cfg_t                cmd_cfg,
    input wire hbgd_fault_t              fault,
    input wire logic [NUM_HB-1:0]        ds_ov,
    input wire logic [NUM_HB-1:0]        oc,
    input wire logic                     drv_active,
    input wire logic [NUM_HB-1:0]        trip_state,
    input wire hbgd_drive_t [NUM_HB-1:0] hs_drv,
    input wire hbgd_drive_t [NUM_HB-1:0] ls_drv,
    input wire logic [NUM_HB-1:0]        high_side_switch,
    input wire logic [NUM_HB-1:0]        low_side_switch
);
    logic [NUM_HB-1:0] hs_src; // Source bit of each high-side drive.
    logic [NUM_HB-1:0] ls_src; // Source bit of each low-side drive.
    logic [NUM_HB-1:0] drv_en; // Either driver of the bridge is enabled.

    // Gather the per-bridge drive bits into plain vectors.
    always_comb begin
        for (int i = 0; i < NUM_HB; i++) begin
            hs_src[i] = hs_drv[i].source;
            ls_src[i] = ls_drv[i].source;
            drv_en[i] = hs_drv[i].en | ls_drv[i].en;
        end
    end

    // All checks share the one clock; all but a_reset_quiet are disabled by its reset.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_reset_quiet: assert property (
        disable iff (1'b0) rst |=> !drv_active && trip_state == '0 && drv_en == '0)
        else $error("outputs not quiet after reset");
    a_no_shoot: assert property (
        (high_side_switch & low_side_switch) == '0)
        else $error("both switches of a bridge on");
    a_switch_src: assert property (
        high_side_switch == hs_src && low_side_switch == ls_src)
        else $error("switch flags differ from drive source");
    a_en_low: assert property (
        (!en) [*5] |-> !drv_active && (high_side_switch | low_side_switch) == '0)
        else $error("active with enable low");
    a_passive_float: assert property (
        (!en) [*5] |-> drv_en == '0)
        else $error("drivers enabled in passive mode");
    a_fault_drop: assert property (
        (fault != '0) [*5] |-> !drv_active)
        else $error("active during device fault");
    a_trip_sink: assert property (
        (trip_state & $past(trip_state) & (hs_src | ls_src)) == '0)
        else $error("tripped bridge still sourcing");
    a_ds_trip: assert property (
        drv_active && en && ds_ov[0] |-> ##[1:3] trip_state[0])
        else $error("drain-source fault did not trip");
    a_cmd_reacts: assert property (
        cmd_valid && en && fault == '0 && cmd_cfg.mode[0] == 2'h2 && ds_ov == '0
        && oc == '0 ##1 en [*2] |-> ##[0:1] hs_drv[0].en)
        else $error("command not applied in time");
endmodule

// >>> hbgd_fet.sv
// Behavioural model of the external MOSFET gates driven by the block.
`timescale 1ns/1ps

module hbgd_fet
    import hbgd_pkg::*;
#(
    parameter int NUM_HB = 8 // Number of half-bridges.
) (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire hbgd_drive_t [NUM_HB-1:0] hs_drv,
    input  wire hbgd_drive_t [NUM_HB-1:0] ls_drv,
    output logic [NUM_HB-1:0]             hs_gate, // High-side MOSFET conducts.
    output logic [NUM_HB-1:0]             ls_gate  // Low-side MOSFET conducts.
);
    logic [NUM_HB-1:0][3:0] hs_q_r; // Gate charge of each high side.
    logic [NUM_HB-1:0][3:0] ls_q_r; // Gate charge of each low side.

    // A sourced gate gains a step; hard-off empties it; anything else, a floating
    // gate too, loses a step, so a released gate is never kept on for free.
    function automatic logic [3:0] q_nxt(input hbgd_drive_t d, input logic [3:0] q);
        if (d.en && d.source) begin
            return (q == 4'hF) ? q : q + 4'h1;
        end
        if (d.en && d.hard) begin
            return 4'h0;
        end
        return (q == 4'h0) ? q : q - 4'h1;
    endfunction

    // Gate charge follows the drives each cycle.
    always_ff @(posedge mclk) begin
        for (int i = 0; i < NUM_HB; i++) begin
            hs_q_r[i] <= rst ? 4'h0 : q_nxt(hs_drv[i], hs_q_r[i]);
            ls_q_r[i] <= rst ? 4'h0 : q_nxt(ls_drv[i], ls_q_r[i]);
        end
    end

    // A MOSFET conducts once its gate holds half the charge or more.
    always_comb begin
        for (int i = 0; i < NUM_HB; i++) begin
            hs_gate[i] = hs_q_r[i][3];
            ls_gate[i] = ls_q_r[i][3];
        end
    end
endmodule

// >>> tb_top.sv
// Self-checking testbench of the half-bridge gate mode control block.
`timescale 1ns/1ps

module tb_top;
    import hbgd_pkg::*;
    logic              mclk;         // Logic clock, 200 MHz.
    logic              rst;          // Synchronous reset.
    logic              en;           // Enable pin.
    logic              cmd_valid;    // Command strobe.
    hbgd_cfg_t         cfg;          // Configuration sent by commands.
    hbgd_fault_t       fault;        // Device faults.
    logic [7:0]        ds_ov;        // Drain-source faults.
    logic [7:0]        oc;           // Overcurrent faults.
    logic              drv_active;   // Drivers active.
    logic [7:0]        trip_state;   // Bridges shut down.
    hbgd_drive_t [7:0] hs_drv;       // High-side drives.
    hbgd_drive_t [7:0] ls_drv;       // Low-side drives.
    logic [7:0]        hss;          // High sides on.
    logic [7:0]        lss;          // Low sides on.
    logic [7:0]        hs_gate;      // High-side MOSFETs conducting.
    logic [7:0]        ls_gate;      // Low-side MOSFETs conducting.
    int                mismatches;   // Failed comparisons.
    int                total_checks; // All comparisons.

    hbgd_ctrl #(.NUM_HB(8), .TW(8)) uut (
        .mclk(mclk), .rst(rst), .en(en), .cmd_valid(cmd_valid), .cmd_cfg(cfg),
        .fault(fault), .ds_ov(ds_ov), .oc(oc), .drv_active(drv_active),
        .trip_state(trip_state), .hs_drv(hs_drv), .ls_drv(ls_drv),
        .high_side_switch(hss), .low_side_switch(lss));
    hbgd_fet #(.NUM_HB(8)) fets (.mclk(mclk), .rst(rst), .hs_drv(hs_drv), .ls_drv(ls_drv),
        .hs_gate(hs_gate), .ls_gate(ls_gate));

    // Wait some edges, then step just past the last one.
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Compare a flag vector.
    task automatic chk_bit(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Compare one gate drive.
    task automatic chk_drv(input string what, input hbgd_drive_t exp, input hbgd_drive_t got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Build a drive value.
    function automatic hbgd_drive_t d(input int e, s, h, input logic [3:0] c);
        return '{e[0], s[0], h[0], c};
    endfunction
    // Send the configuration as one command; returns just after the taking edge.
    task automatic send();
        cmd_valid = 1'b1;
        step(1);
        cmd_valid = 1'b0;
    endtask
    // Print the counts and the verdict, then stop.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Outputs stay quiet out of reset; bypass set and modes off keep it passive.
    task automatic t_reset();
        chk_bit("reset flags", 8'h00, {4'h0, drv_active, trip_state[0], hss[0], lss[0]});
        chk_drv("reset drive", d(0, 0, 0, 4'h4), hs_drv[0]);
    endtask
    // Every mode code with bypass set: only 01 and 10 make it active.
    task automatic t_table();
        for (int c = 0; c < 4; c++) begin
            cfg.mode[3] = c[1:0];
            send();
            step(12);
            chk_bit("mode table", {4'h0, c == 1 || c == 2, c == 1 || c == 2, c == 2, c == 1},
                {4'h0, drv_active, hs_drv[3].en, hss[3], lss[3]});
        end
    endtask
    // Active entry, then two bridges charging with their own blank times.
    task automatic t_charge();
        cfg.mode = '0;
        send();
        step(1);
        cfg.bypass = 1'b0;
        send();
        step(3);
        chk_bit("active", 8'h01, {7'h0, drv_active});
        chk_drv("idle hold", d(1, 0, 0, 4'h4), ls_drv[7]);
        cfg.mode[0] = 2'h2;
        cfg.mode[1] = 2'h2;
        cfg.blank_time[0] = 8'h04;
        cfg.blank_time[1] = 8'h01;
        send();
        step(2);
        chk_drv("hb0 charge", d(1, 1, 0, 4'h0), hs_drv[0]);
        chk_drv("hb1 charge", d(1, 1, 0, 4'hF), hs_drv[1]);
        chk_bit("hb0 hard", 8'h05, {5'h0, ls_drv[0].en, ls_drv[0].source, ls_drv[0].hard});
        step(2);
        chk_drv("hb1 hold", d(1, 1, 0, 4'h4), hs_drv[1]);
        chk_drv("hb0 still", d(1, 1, 0, 4'h0), hs_drv[0]);
        step(3);
        chk_drv("hb0 hold", d(1, 1, 0, 4'h4), hs_drv[0]);
        chk_drv("hb0 ls hold", d(1, 0, 0, 4'h4), ls_drv[0]);
    endtask
    // Low side on, then swapped to the high side through the guard time.
    task automatic t_swap();
        cfg.hold_sel = 1'b1;
        cfg.mode[0] = 2'h1;
        send();
        step(14);
        chk_drv("ls hold hi", d(1, 1, 0, 4'h6), ls_drv[0]);
        cfg.ccp_time[0] = 8'h03;
        cfg.mode[0] = 2'h2;
        send();
        step(2);
        chk_drv("guard hs", d(1, 0, 0, 4'h0), hs_drv[0]);
        step(2);
        chk_drv("guard ls", d(1, 0, 0, 4'h0), ls_drv[0]);
        step(2);
        chk_drv("swap charge", d(1, 1, 0, 4'h0), hs_drv[0]);
        chk_bit("swap hard", 8'h05, {5'h0, ls_drv[0].en, ls_drv[0].source, ls_drv[0].hard});
    endtask
    // High side on, then both commanded off.
    task automatic t_off();
        step(10);
        cfg.mode[0] = 2'h3;
        send();
        step(2);
        chk_drv("off guard", d(1, 0, 0, 4'h0), hs_drv[0]);
        step(4);
        chk_drv("off hold hs", d(1, 0, 0, 4'h6), hs_drv[0]);
        chk_drv("off hold ls", d(1, 0, 0, 4'h6), ls_drv[0]);
    endtask
    // Enable low forces passive; raising it again resumes with no command.
    task automatic t_en();
        cfg.mode[0] = 2'h2;
        send();
        step(10);
        en = 1'b0;
        step(6);
        chk_bit("en low", 8'h00, {5'h0, drv_active, hss[0], hs_drv[0].en});
        en = 1'b1;
        step(10);
        chk_bit("en high", 8'h03, {6'h0, drv_active, hss[0]});
    endtask
    // Each device fault, then bridge faults with overcurrent shutdown off and on.
    task automatic t_fault();
        cfg.mode[0] = 2'h1;
        for (int i = 0; i < 5; i++) begin
            send();
            step(12);
            fault = 5'h01 << i;
            step(6);
            chk_bit("dev fault", 8'h02, {5'h0, drv_active, trip_state[0], lss[0]});
            chk_drv("fault sink", d(1, 0, 0, 4'h0), ls_drv[0]);
            fault = '0;
            step(2);
        end
        for (int k = 0; k < 3; k++) begin
            cfg.overcurrent_shutdown_enable = (k == 2);
            send();
            step(12);
            ds_ov[0] = (k == 0);
            oc[0] = (k != 0);
            step(4);
            chk_bit("hb fault", {6'h0, 1'b1, k != 1}, {6'h0, drv_active, trip_state[0]});
            ds_ov = '0;
            oc = '0;
            step(2);
        end
        send();
        step(3);
        chk_bit("trip clear", 8'h00, {7'h0, trip_state[0]});
    endtask

    // Free-running logic clock.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Neither MOSFET pair may conduct together, checked between edges.
    always @(negedge mclk) begin
        if (!rst) begin
            chk_bit("shoot through", 8'h00, hs_gate & ls_gate);
        end
    end

    // Main sequence.
    initial begin
        rst = 1'b1;
        en = 1'b1;
        cmd_valid = 1'b0;
        cfg = '0;
        cfg.bypass = 1'b1;
        cfg.cur[1] = 4'hF;
        fault = '0;
        ds_ov = '0;
        oc = '0;
        mismatches = 0;
        total_checks = 0;
        step(16);
        rst = 1'b0;
        step(5);
        t_reset();
        t_table();
        t_charge();
        t_swap();
        t_off();
        t_en();
        t_fault();
        report_and_stop();
    end

    // Cut a hang short; the tests need well under a tenth of this span.
    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end
endmodule

bind hbgd_ctrl hbgd_chk #(.NUM_HB(NUM_HB), .TW(TW)) u_chk (
    .mclk(mclk), .rst(rst), .en(en), .cmd_valid(cmd_valid), .cmd_cfg(cmd_cfg),
    .fault(fault), .ds_ov(ds_ov), .oc(oc), .drv_active(drv_active),
    .trip_state(trip_state), .hs_drv(hs_drv), .ls_drv(ls_drv),
    .high_side_switch(high_side_switch), .low_side_switch(low_side_switch));
